// >>> lmbs_top.sv
// Purpose: link controller mode, bit rate and checksum setup behind an AHB-Lite slave
// Assumes: single word transfers, non-pipelined master, zero wait states
// Notes: registers hold up to 8 bits in the low byte of each word; upper bits read zero
//
// Summary of operation
// - bit 6 of the mode register chooses master (1) or slave (0) operation.
// - master/slave choice and autobaud choice live in the directly addressed mode register.
// - bit 5 of the mode register chooses automatic (1) or manual (0) bit rate on a slave; a master runs manual either way.
// - registers other than mode, index, data, status and mask are reached only through the index and data registers.
// - the index register picks which inner register a data access reaches.
// - manual bit rate is clock over 2^(prescaler+1) times divider times (multiplier+1).
// - prescaler 0..3, multiplier 0..31, divider 200..511; a divider below 200 is flagged.
// - the rate factors sit in the indirect divider and scale registers.
// - checksums are summed and checked in hardware, classic or enhanced.
// - status is readable for polling and also drives a masked interrupt.
// - scale register holds prescaler high, multiplier in the middle, divider bit 8 lowest.
// - autobaud uses prescaler and divider only, aimed at a 20000 bit/s reference.
`timescale 1ns/1ns
`include "lmbs_regs.svh"
module lmbs_top
  import lmbs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  output logic link_active,
  output logic node_master,
  output logic auto_rate,
  output logic config_invalid,
  output logic checksum_enhanced,
  output logic bit_tick,
  input wire logic cks_start,
  input wire logic [7:0] cks_pid,
  input wire logic cks_valid,
  input wire logic cks_check,
  input wire logic [7:0] cks_data,
  output logic [7:0] cks_sum,
  output logic cks_done,
  output logic cks_bad
);

  // carry-wrapped byte sum used by both checksum types
  function automatic logic [7:0] cks_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    cks_add = 8'(s[7:0] + {7'h00, s[8]});
  endfunction

  lmbs_phase_e phase;
  logic [7:0] ph_addr;
  lmbs_mode_s mode;
  logic [7:0] index;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [7:0] ck_acc;
  lmbs_timing_s timing;
  logic [7:0] ind_rdata;
  logic ind_enhanced;
  logic tick_raw;

  // address phase decode
  wire addr_phase = hsel && hready && htrans[1];
  wire [7:0] a_ofs = haddr[7:0];
  wire a_mapped = (haddr[31:8] == 24'h000000) && (a_ofs[1:0] == 2'h0);
  wire rd_mode = a_mapped && (a_ofs == `LMBS_OFS_MODE);
  wire rd_index = a_mapped && (a_ofs == `LMBS_OFS_INDEX);
  wire rd_data = a_mapped && (a_ofs == `LMBS_OFS_DATA);
  wire rd_status = a_mapped && (a_ofs == `LMBS_OFS_IRQ_STATUS);
  wire rd_mask = a_mapped && (a_ofs == `LMBS_OFS_IRQ_MASK);
  wire read_take = addr_phase && !hwrite;
  wire status_read = read_take && rd_status;

  // data phase write decode
  wire wr_phase = phase == PH_WRITE;
  wire wr_mode = wr_phase && (ph_addr == `LMBS_OFS_MODE);
  wire wr_index = wr_phase && (ph_addr == `LMBS_OFS_INDEX);
  wire wr_data = wr_phase && (ph_addr == `LMBS_OFS_DATA);
  wire wr_mask = wr_phase && (ph_addr == `LMBS_OFS_IRQ_MASK);
  wire [7:0] wbyte = hwdata[7:0];

  wire [7:0] mode_byte = {mode.active, mode.master, mode.auto_rate, 5'h00};
  wire [7:0] rd_byte = rd_mode ? mode_byte :
                       rd_index ? index :
                       rd_data ? ind_rdata :
                       rd_status ? {5'h00, irq_status} :
                       rd_mask ? {5'h00, irq_mask} : 8'h00;

  // checksum path; start outranks check, check outranks a data byte
  wire [7:0] ck_step = cks_add(ck_acc, cks_data);
  wire [7:0] ck_seed = ind_enhanced ? cks_pid : 8'h00;
  wire [7:0] next_ck_acc = cks_start ? ck_seed : (cks_valid && !cks_check) ? ck_step : ck_acc;
  wire ck_ok = ck_step == 8'hff;
  wire ev_done = mode.active && cks_check && !cks_start;
  wire ev_bad = ev_done && !ck_ok;

  // invalid setup: autobaud on a master, or divider below its floor
  wire next_invalid = mode.active && ((mode.master && mode.auto_rate) ||
                      (timing.divider < `LMBS_DIV_MIN));
  wire ev_cfg = next_invalid && !config_invalid;

  wire [2:0] events = {ev_cfg, ev_bad, ev_done};
  // a read clears, but an event in the same cycle survives
  wire [2:0] next_irq_status = (status_read ? 3'h0 : irq_status) | events;

  lmbs_indirect_regs u_indirect (
    .clock(clock),
    .rstn(rstn),
    .wr(wr_data),
    .index(index),
    .wdata(wbyte),
    .rdata(ind_rdata),
    .timing(timing),
    .enhanced(ind_enhanced)
  );

  lmbs_bit_timer u_timer (
    .clock(clock),
    .rstn(rstn),
    .enable(mode.active),
    .auto_rate(mode.auto_rate && !mode.master),
    .timing(timing),
    .bit_tick(tick_raw)
  );

  // bus phase tracking and read data; zero wait states
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase <= PH_IDLE;
      ph_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase) begin
        phase <= hwrite ? PH_WRITE : PH_READ;
        ph_addr <= a_mapped ? a_ofs : 8'hff;
      end else begin
        phase <= PH_IDLE;
      end
      if (read_take) begin
        hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // direct registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode <= `LMBS_MODE_RESET;
      index <= 8'h00;
      irq_mask <= `LMBS_IRQ_RESET;
    end else begin
      if (wr_mode) begin
        mode.active <= wbyte[`LMBS_BIT_ACTIVE];
        mode.master <= wbyte[`LMBS_BIT_MASTER];
        mode.auto_rate <= wbyte[`LMBS_BIT_AUTO_RATE];
      end
      if (wr_index) begin
        index <= wbyte;
      end
      if (wr_mask) begin
        irq_mask <= wbyte[2:0];
      end
    end
  end

  // status, interrupt and mirrored outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_status <= `LMBS_IRQ_RESET;
      irq <= 1'b0;
      config_invalid <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
      config_invalid <= next_invalid;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_active <= 1'b0;
      node_master <= 1'b0;
      auto_rate <= 1'b0;
      checksum_enhanced <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      link_active <= mode.active;
      node_master <= mode.master;
      auto_rate <= mode.auto_rate;
      checksum_enhanced <= ind_enhanced;
      bit_tick <= tick_raw;
    end
  end

  // checksum accumulator; sum output is the inverted running total
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ck_acc <= 8'h00;
      cks_sum <= 8'hff;
      cks_done <= 1'b0;
      cks_bad <= 1'b0;
    end else begin
      ck_acc <= next_ck_acc;
      cks_sum <= ~next_ck_acc;
      cks_done <= ev_done;
      cks_bad <= ev_bad;
    end
  end

endmodule

// >>> lmbs_regs.svh
// Purpose: register offsets, field positions and reset values of the link mode and bit rate setup block
// Assumes: byte addresses on a 32-bit AHB-Lite bus, one register per aligned word
// Notes: indirect indices are byte indices reached through the index and data registers
`ifndef LMBS_REGS_SVH
`define LMBS_REGS_SVH

// directly addressed registers (byte offsets)
`define LMBS_OFS_MODE 8'h00
`define LMBS_OFS_INDEX 8'h04
`define LMBS_OFS_DATA 8'h08
`define LMBS_OFS_IRQ_STATUS 8'h0c
`define LMBS_OFS_IRQ_MASK 8'h10

// link_control_mode_reg fields
`define LMBS_BIT_ACTIVE 7
`define LMBS_BIT_MASTER 6
`define LMBS_BIT_AUTO_RATE 5
`define LMBS_MODE_RESET 3'h0

// indirect register indices
`define LMBS_IDX_FRAME_CFG 8'h0b
`define LMBS_IDX_DIVIDER 8'h0c
`define LMBS_IDX_SCALE 8'h0d

// frame config and bit_scale_reg fields
`define LMBS_BIT_ENHANCED 7
`define LMBS_SCALE_PRE_MSB 7
`define LMBS_SCALE_PRE_LSB 6
`define LMBS_SCALE_MUL_MSB 5
`define LMBS_SCALE_MUL_LSB 1
`define LMBS_SCALE_DIV8 0

// reset values of the indirect registers
`define LMBS_FRAME_CFG_RESET 8'h00
`define LMBS_DIVIDER_RESET 8'hc8
`define LMBS_SCALE_RESET 8'h00

// legal divider range
`define LMBS_DIV_MIN 9'h0c8
`define LMBS_DIV_MAX 9'h1ff

// interrupt status / mask bit positions
`define LMBS_IRQ_DONE 0
`define LMBS_IRQ_BAD 1
`define LMBS_IRQ_CFG 2
`define LMBS_IRQ_RESET 3'h0

`endif

// >>> lmbs_pkg.sv
// Purpose: shared types of the link mode and bit rate setup block
// Assumes: constants live in lmbs_regs.svh
// Notes: none
package lmbs_pkg;

  typedef struct packed {
    logic active;
    logic master;
    logic auto_rate;
  } lmbs_mode_s;

  typedef struct packed {
    logic [1:0] prescale;
    logic [4:0] mult;
    logic [8:0] divider;
  } lmbs_timing_s;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } lmbs_phase_e;

endpackage

// >>> lmbs_bit_timer.sv
// Purpose: bit period tick generator from the system clock
// Assumes: timing fields already within their legal ranges
// Notes: compares use >= so a lowered setting never overruns a counter
`timescale 1ns/1ns
`include "lmbs_regs.svh"
module lmbs_bit_timer
  import lmbs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic enable,
  input wire logic auto_rate,
  input wire lmbs_timing_s timing,
  output logic bit_tick
);

  logic [3:0] pre_cnt;
  logic [8:0] div_cnt;
  logic [4:0] mul_cnt;

  wire [3:0] pre_top = 4'((5'h02 << timing.prescale) - 5'h01);
  // autobaud runs on prescaler and divider only
  wire [4:0] mul_top = auto_rate ? 5'h00 : timing.mult;
  wire [8:0] div_top = 9'(timing.divider - 9'h001);
  wire pre_last = pre_cnt >= pre_top;
  wire div_last = pre_last && (div_cnt >= div_top);
  wire mul_last = div_last && (mul_cnt >= mul_top);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_cnt <= 4'h0;
      div_cnt <= 9'h000;
      mul_cnt <= 5'h00;
      bit_tick <= 1'b0;
    end else if (!enable) begin
      pre_cnt <= 4'h0;
      div_cnt <= 9'h000;
      mul_cnt <= 5'h00;
      bit_tick <= 1'b0;
    end else begin
      pre_cnt <= pre_last ? 4'h0 : 4'(pre_cnt + 4'h1);
      if (pre_last) begin
        div_cnt <= div_last ? 9'h000 : 9'(div_cnt + 9'h001);
      end
      if (div_last) begin
        mul_cnt <= mul_last ? 5'h00 : 5'(mul_cnt + 5'h01);
      end
      bit_tick <= mul_last;
    end
  end

endmodule

// >>> lmbs_indirect_regs.sv
// Purpose: indirectly reached register set (frame config, divider, scale)
// Assumes: wr is a one-cycle pulse with index and wdata valid
// Notes: unknown indices read as zero and ignore writes
`timescale 1ns/1ns
`include "lmbs_regs.svh"
module lmbs_indirect_regs
  import lmbs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr,
  input wire logic [7:0] index,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output lmbs_timing_s timing,
  output logic enhanced
);

  logic [7:0] frame_cfg;
  logic [7:0] divider_low;
  logic [7:0] scale;

  wire sel_cfg = index == `LMBS_IDX_FRAME_CFG;
  wire sel_div = index == `LMBS_IDX_DIVIDER;
  wire sel_scale = index == `LMBS_IDX_SCALE;

  assign rdata = sel_cfg ? frame_cfg : sel_div ? divider_low : sel_scale ? scale : 8'h00;
  assign timing.prescale = scale[`LMBS_SCALE_PRE_MSB:`LMBS_SCALE_PRE_LSB];
  assign timing.mult = scale[`LMBS_SCALE_MUL_MSB:`LMBS_SCALE_MUL_LSB];
  assign timing.divider = {scale[`LMBS_SCALE_DIV8], divider_low};
  assign enhanced = frame_cfg[`LMBS_BIT_ENHANCED];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      frame_cfg <= `LMBS_FRAME_CFG_RESET;
      divider_low <= `LMBS_DIVIDER_RESET;
      scale <= `LMBS_SCALE_RESET;
    end else if (wr) begin
      if (sel_cfg) frame_cfg <= wdata;
      if (sel_div) divider_low <= wdata;
      if (sel_scale) scale <= wdata;
    end
  end

endmodule

// >>> lmbs_properties.sv
// Purpose: port-level checks of the link setup block
// Assumes: zero wait state slave, mirrors one cycle behind their registers
// Notes: bound to lmbs_top at the foot
`timescale 1ns/1ns
module lmbs_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic link_active,
  input wire logic node_master,
  input wire logic auto_rate,
  input wire logic config_invalid,
  input wire logic bit_tick,
  input wire logic checksum_enhanced,
  input wire logic cks_start,
  input wire logic [7:0] cks_pid,
  input wire logic [7:0] cks_sum,
  input wire logic cks_check,
  input wire logic cks_done,
  input wire logic cks_bad
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic mode_wr = hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
  AST_BUS_OKAY: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0) else $error("bus answer wrong");
  // register lands at the data phase edge, its mirror one edge later
  AST_MASTER_BIT: assert property (mode_wr |-> ##3 node_master == $past(hwdata[6], 2))
    else $error("master bit");
  AST_AUTO_BIT: assert property (mode_wr |-> ##3 auto_rate == $past(hwdata[5], 2))
    else $error("autobaud bit");
  AST_ACTIVE_BIT: assert property (mode_wr |-> ##3 link_active == $past(hwdata[7], 2))
    else $error("active bit");
  AST_MASTER_AUTO: assert property (link_active && node_master && auto_rate |-> config_invalid)
    else $error("master autobaud not flagged");
  AST_INVALID_IDLE: assert property (config_invalid |-> link_active) else $error("flag while inactive");
  AST_TICK_PULSE: assert property (bit_tick |=> !bit_tick[*8]) else $error("tick too long");
  AST_TICK_OFF: assert property (!link_active [*3] |-> !bit_tick) else $error("tick while inactive");
  AST_DONE_CAUSE: assert property (cks_done |-> $past(cks_check && !cks_start)) else $error("stray done");
  AST_BAD_DONE: assert property (cks_bad |-> cks_done) else $error("bad without done");
  // frame config is held steady around a start, so the mirror stands for it
  AST_SEED: assert property (cks_start |=> cks_sum == ~($past(checksum_enhanced) ? $past(cks_pid) : 8'h00))
    else $error("checksum seed");
endmodule
bind lmbs_top lmbs_chk u_chk (.*);

// >>> lmbs_frame_peer.sv
// Purpose: stand-in for the far node feeding frame bytes to the checksum port
// Assumes: go is a one-cycle pulse, enh matches the frame config bit
// Notes: corrupt flips bit 0 of the sent checksum so the receiver must flag it
`timescale 1ns/1ns
module lmbs_frame_peer (
  input wire logic clock,
  input wire logic rstn,
  input wire logic go,
  input wire logic enh,
  input wire logic [7:0] pid,
  input wire logic corrupt,
  output logic cks_start,
  output logic [7:0] cks_pid,
  output logic cks_valid,
  output logic cks_check,
  output logic [7:0] cks_data
);
  logic [1:0] st;
  logic [7:0] acc;
  function automatic logic [7:0] add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h0, s[8]};
  endfunction
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= 2'h0;
      {cks_start, cks_valid, cks_check} <= 3'h0;
      cks_data <= 8'h00;
      cks_pid <= 8'h00;
      acc <= 8'h00;
    end else begin
      {cks_start, cks_valid, cks_check} <= 3'h0;
      // idle data line toggles so stale bytes never look valid
      cks_data <= ~cks_data;
      case (st)
        2'h0: if (go) begin
          cks_start <= 1'b1;
          cks_pid <= pid;
          acc <= enh ? pid : 8'h00;
          st <= 2'h1;
        end
        2'h3: begin
          cks_check <= 1'b1;
          cks_data <= ~acc ^ {7'h0, corrupt};
          st <= 2'h0;
        end
        default: begin
          cks_valid <= 1'b1;
          cks_data <= 8'h4a + {6'h0, st};
          acc <= add(acc, 8'h4a + {6'h0, st});
          st <= st + 2'h1;
        end
      endcase
    end
  end
endmodule

// >>> test_lin_mode_and_baud_setup.sv
// Purpose: self-checking bench of the link setup block
// Assumes: zero wait state AHB-Lite slave
// Notes: bit timer runs at full divider values, a few thousand cycles
`timescale 1ns/1ns
module test_lin_mode_and_baud_setup;
  import lmbs_pkg::*;
  logic clock, rstn, hsel, hwrite, hready, hreadyout, hresp, irq, link_active, node_master, auto_rate;
  logic config_invalid, checksum_enhanced, bit_tick, cks_start, cks_valid, cks_check, cks_done, cks_bad;
  logic go, enh, corrupt;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] cks_pid, cks_data, cks_sum, pid;
  int n_fail, cmp_count, cyc;
  logic [7:0] rows [0:8][0:2] = '{'{8'h00, 8'hff, 8'he0}, '{8'h04, 8'h0b, 8'h0b}, '{8'h08, 8'h80, 8'h80},
    '{8'h04, 8'h0c, 8'h0c}, '{8'h08, 8'hc8, 8'hc8}, '{8'h04, 8'h0e, 8'h0e}, '{8'h08, 8'h55, 8'h00},
    '{8'h14, 8'h33, 8'h00}, '{8'h10, 8'h07, 8'h07}};
  assign hready = hreadyout;
  lmbs_top u_dut (.*);
  lmbs_frame_peer u_peer (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
    xfer(1'b0, a, 32'h0);
    chk(s, e, rv);
  endtask
  task automatic settle();
    repeat (3) @(negedge clock);
  endtask
  task automatic gap(input int e);
    int n;
    repeat (2) begin
      n = 1;
      @(negedge clock);
      while (bit_tick !== 1'b1) begin
        @(negedge clock);
        n++;
      end
    end
    chk("tick gap", e, n);
  endtask
  task automatic frame(input logic e, input logic [7:0] p, input logic c);
    enh <= e;
    pid <= p;
    corrupt <= c;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    do @(negedge clock); while (cks_done !== 1'b1);
    chk("cks_bad", c, cks_bad);
    chk("cks_sum", {24'h0, ~u_peer.acc}, {24'h0, cks_sum});
    chk("irq", 1, irq);
    rd(32'h0c, {30'h0, c, 1'b1}, "status");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {rstn, hsel, hwrite, go, enh, corrupt} = 6'h0;
    {haddr, hwdata, htrans, pid} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      wr({24'h0, rows[i][0]}, {24'h0, rows[i][1]});
      rd({24'h0, rows[i][0]}, {24'h0, rows[i][2]}, "table reg");
    end
    $display("table rows done");
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(32'h00, 32'h0, "mode");
    rd(32'h10, 32'h0, "mask");
    wr(32'h04, 32'h0c);
    rd(32'h08, 32'hc8, "divider");
    wr(32'h04, 32'h0b);
    rd(32'h08, 32'h0, "frame cfg");
    $display("reset test done");
    wr(32'h00, 32'h80);
    gap(400);
    wr(32'h04, 32'h0d);
    wr(32'h08, 32'h02);
    gap(800);
    wr(32'h00, 32'ha0);
    gap(400);
    wr(32'h08, 32'h41);
    wr(32'h00, 32'h80);
    gap(1824);
    $display("bit timer test done");
    wr(32'h00, 32'he0);
    settle();
    chk("invalid", 1, config_invalid);
    chk("masked irq", 0, irq);
    wr(32'h10, 32'h04);
    settle();
    chk("irq", 1, irq);
    rd(32'h0c, 32'h04, "status");
    settle();
    chk("irq cleared", 0, irq);
    wr(32'h00, 32'h80);
    wr(32'h08, 32'h00);
    wr(32'h04, 32'h0c);
    wr(32'h08, 32'h10);
    settle();
    chk("low divider", 1, config_invalid);
    rd(32'h0c, 32'h04, "status");
    wr(32'h08, 32'hc8);
    $display("invalid test done");
    wr(32'h10, 32'h03);
    frame(1'b0, 8'h00, 1'b0);
    frame(1'b0, 8'h00, 1'b1);
    wr(32'h04, 32'h0b);
    wr(32'h08, 32'h80);
    settle();
    chk("enhanced", 1, checksum_enhanced);
    frame(1'b1, 8'h97, 1'b0);
    $display("checksum test done");
    conclude();
  end
endmodule
